// >>> src/hrc_map.svh
// Register map, field positions and reset values of the homing reference control
`ifndef HRC_MAP_SVH
`define HRC_MAP_SVH

// ************************************************************
// Byte offsets
// ************************************************************
`define HRC_CTRL_OFS     8'h00
`define HRC_MODE_OFS     8'h04
`define HRC_WIN_OFS      8'h08
`define HRC_STAT_OFS     8'h0C
`define HRC_POS_OFS      8'h10
`define HRC_ANGLE_OFS    8'h14

// ************************************************************
// Control fields
// ************************************************************
`define HRC_C_START      0
`define HRC_C_POSTPOS    1
`define HRC_C_SWAP       2
`define HRC_C_INV_HOME   3
`define HRC_C_INV_POS    4
`define HRC_C_INV_NEG    5
`define HRC_C_CUR_REV    6
`define HRC_C_HOME_EN    7
`define HRC_C_DOWNLOAD   8
`define HRC_C_FB_LO      9
`define HRC_C_FB_HI      10
`define HRC_C_CHECK      12

// ************************************************************
// Status fields
// ************************************************************
`define HRC_S_BUSY       0
`define HRC_S_REF        1
`define HRC_S_FAULT      2
`define HRC_S_REQ        3
`define HRC_S_SWLIM      4
`define HRC_S_REF_WORD   12

// ************************************************************
// Reset values and limits
// ************************************************************
`define HRC_CTRL_RST     13'h0000
`define HRC_MODE_RST     8'h00
`define HRC_WIN_RST      16'h0400
`define HRC_HALF_TURN    16'h8000
`define HRC_MODE_HERE    8'h23

`endif

// >>> src/hrc_pkg.sv
// Types shared by the homing reference control
package hrc_pkg;

  typedef enum logic [2:0] {
    HRC_ST_IDLE   = 3'b000,
    HRC_ST_SEARCH = 3'b001,
    HRC_ST_ZERO   = 3'b010,
    HRC_ST_GOTO   = 3'b011,
    HRC_ST_STOP   = 3'b100
  } hrc_state_type;

  typedef enum logic [2:0] {
    HRC_SRC_HOME_EDGE = 3'b000,
    HRC_SRC_HOME_ZP   = 3'b001,
    HRC_SRC_LIMIT     = 3'b010,
    HRC_SRC_ZP        = 3'b011,
    HRC_SRC_BLOCK     = 3'b100,
    HRC_SRC_HERE      = 3'b101
  } hrc_src_type;

  typedef enum logic [1:0] {
    HRC_FB_INCR = 2'b00,
    HRC_FB_ABS  = 2'b01,
    HRC_FB_EMU  = 2'b10
  } hrc_fb_type;

  typedef struct packed {
    logic        valid;
    hrc_src_type src;
    logic        dir_pos;
    logic        rising;
    logic        home_lvl;
    logic        use_rev;
  } hrc_mode_type;

  typedef struct packed {
    logic home;
    logic pos;
    logic neg;
    logic zp;
  } hrc_sw_type;

endpackage : hrc_pkg

// >>> src/hrc_top.sv
// Homing and position reference control with an AHB-Lite register slave
//
// Summary of operation
// - With homing enabled, first start after each configuration download runs homing.
// - Post-homing positioning moves to 0; otherwise the drive just brakes and stops.
// - Multiturn absolute feedback is referenced by the check strobe; no homing run needed.
// - A configuration download demands a new reference run unless a run finishes in the same cycle.
// - Mode 35 takes machine zero at the current position, no switch needed.
// - Emulated multiturn keeps position only if motor moved under half a turn.
// - Emulation check inside window sets referenced status bit 12 and output.
// - Window exceeded means not referenced and software end limits disabled.
// - Modes 19-22 use home switch edge only; 19/20 positive, 21/22 negative side.
// - Modes 3-6 use home switch plus zero pulse; 3/4 positive, 5/6 negative.
// - Modes 7-14 add reversal switches to zero pulse; 23-30 reversal without pulse.
// - Modes 128 and 129 take machine zero by driving against a block.
// - Modes 1,2,17,18,132,133 use a limit switch; 33,34,130,131 zero pulse only.
// - The feedback zero pulse refines machine zero.
// - Without reversal switches, a current threshold may reverse the search.
// - Switch decisions use logic states after the configurable inversion.
// - Positive and negative reversal switch inputs may be swapped.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`include "hrc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module hrc_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_HOME_SW,
  input  wire logic        I_SWITCH_A,
  input  wire logic        I_SWITCH_B,
  input  wire logic        I_ZERO_PULSE,
  input  wire logic        I_CURRENT_LIMIT,
  input  wire logic        I_IN_POS,
  input  wire logic [31:0] I_POSITION,
  input  wire logic [15:0] I_ANGLE,
  output logic             O_MOVE_EN,
  output logic             O_MOVE_DIR,
  output logic             O_SET_ZERO,
  output logic             O_GOTO_ZERO,
  output logic             O_BRAKE,
  output logic             O_REFERENCED,
  output logic             O_SW_LIMIT_EN
);

  // ************************************************************
  // Mode code decoding
  // ************************************************************
  function automatic hrc_pkg::hrc_mode_type decode_mode(input logic [7:0] c);
    hrc_pkg::hrc_mode_type m;
    m = '0;
    m.valid = 1'b1;
    m.dir_pos = ~c[0];
    if (c >= 8'h03 && c <= 8'h0E) begin
      m.src = hrc_pkg::HRC_SRC_HOME_ZP;
      m.home_lvl = ~c[0];
      m.use_rev = (c >= 8'h07);
      m.dir_pos = (c <= 8'h04) || (c >= 8'h07 && c <= 8'h0A);
    end else if (c >= 8'h13 && c <= 8'h1E) begin
      m.src = hrc_pkg::HRC_SRC_HOME_EDGE;
      m.rising = ~c[0];
      m.use_rev = (c >= 8'h17);
      m.dir_pos = (c <= 8'h14) || (c >= 8'h17 && c <= 8'h1A);
    end else if (c == 8'h01 || c == 8'h02 || c == 8'h11 || c == 8'h12 || c == 8'h84 || c == 8'h85) begin
      m.src = hrc_pkg::HRC_SRC_LIMIT;
    end else if (c == 8'h21 || c == 8'h22 || c == 8'h82 || c == 8'h83) begin
      m.src = hrc_pkg::HRC_SRC_ZP;
    end else if (c == 8'h80 || c == 8'h81) begin
      m.src = hrc_pkg::HRC_SRC_BLOCK;
    end else if (c == `HRC_MODE_HERE) begin
      m.src = hrc_pkg::HRC_SRC_HERE;
    end else begin
      m.valid = 1'b0;
    end
    return m;
  endfunction : decode_mode

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_raw;
  logic [3:0] sync1_q, sync2_q, sync3_q, pin_q;
  assign pin_raw = {I_HOME_SW, I_SWITCH_A, I_SWITCH_B, I_ZERO_PULSE};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pin_q[gi]   <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          // Glitch guard: only a level seen twice counts
          if (sync2_q[gi] == sync3_q[gi]) begin
            pin_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Register slave
  // ************************************************************
  logic [12:0] ctrl_q;
  logic [7:0]  mode_q;
  logic [15:0] win_q;
  logic [15:0] angle_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        acc;
  logic        start_w, dl_w, chk_w, fclr_w;

  assign acc         = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign start_w = wr_q && addr_q == `HRC_CTRL_OFS && I_HWDATA[`HRC_C_START];
  assign dl_w    = wr_q && addr_q == `HRC_CTRL_OFS && I_HWDATA[`HRC_C_DOWNLOAD];
  assign chk_w   = wr_q && addr_q == `HRC_CTRL_OFS && I_HWDATA[`HRC_C_CHECK];
  assign fclr_w  = wr_q && addr_q == `HRC_STAT_OFS && I_HWDATA[`HRC_S_FAULT];

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= acc && I_HWRITE;
      addr_q <= I_HADDR[7:0];
    end
  end

  // Strobe bits are not stored; they act only in their write cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q  <= `HRC_CTRL_RST;
      mode_q  <= `HRC_MODE_RST;
      win_q   <= `HRC_WIN_RST;
      angle_q <= 16'h0000;
    end else if (wr_q) begin
      unique case (addr_q)
        `HRC_CTRL_OFS: begin
          ctrl_q <= I_HWDATA[12:0] & 13'h06FE;
        end
        `HRC_MODE_OFS:  mode_q  <= I_HWDATA[7:0];
        `HRC_WIN_OFS:   win_q   <= I_HWDATA[15:0];
        `HRC_ANGLE_OFS: angle_q <= I_HWDATA[15:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Switch logic states
  // ************************************************************
  hrc_pkg::hrc_sw_type sw, sw_prev_q;
  hrc_pkg::hrc_fb_type fb;
  logic home_rise, home_fall, pos_rise, neg_rise, zp_rise;

  assign fb      = hrc_pkg::hrc_fb_type'(ctrl_q[`HRC_C_FB_HI:`HRC_C_FB_LO]);
  assign sw.home = pin_q[3] ^ ctrl_q[`HRC_C_INV_HOME];
  assign sw.pos  = (ctrl_q[`HRC_C_SWAP] ? pin_q[1] : pin_q[2]) ^ ctrl_q[`HRC_C_INV_POS];
  assign sw.neg  = (ctrl_q[`HRC_C_SWAP] ? pin_q[2] : pin_q[1]) ^ ctrl_q[`HRC_C_INV_NEG];
  assign sw.zp   = pin_q[0];

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sw_prev_q <= '0;
    end else begin
      sw_prev_q <= sw;
    end
  end

  assign home_rise = sw.home && !sw_prev_q.home;
  assign home_fall = !sw.home && sw_prev_q.home;
  assign pos_rise  = sw.pos && !sw_prev_q.pos;
  assign neg_rise  = sw.neg && !sw_prev_q.neg;
  assign zp_rise   = sw.zp && !sw_prev_q.zp;

  // ************************************************************
  // Homing sequence
  // ************************************************************
  hrc_pkg::hrc_state_type state_q, state_d;
  hrc_pkg::hrc_mode_type  mcfg, run_q;
  logic dir_q, rev_q, rev_now, found, accept, req_q, ref_q, fault_q;

  assign mcfg   = decode_mode(mode_q);
  assign accept = start_w && state_q == hrc_pkg::HRC_ST_IDLE && ctrl_q[`HRC_C_HOME_EN] && req_q;
  assign rev_now = (run_q.use_rev && (dir_q ? sw.pos : sw.neg))
                || (!run_q.use_rev && ctrl_q[`HRC_C_CUR_REV] && I_CURRENT_LIMIT
                    && run_q.src != hrc_pkg::HRC_SRC_BLOCK);

  always_comb begin
    found = 1'b0;
    unique case (run_q.src)
      hrc_pkg::HRC_SRC_HOME_EDGE: found = run_q.rising ? home_rise : home_fall;
      hrc_pkg::HRC_SRC_HOME_ZP:   found = zp_rise && sw.home == run_q.home_lvl;
      hrc_pkg::HRC_SRC_LIMIT:     found = dir_q ? pos_rise : neg_rise;
      hrc_pkg::HRC_SRC_ZP:        found = zp_rise;
      hrc_pkg::HRC_SRC_BLOCK:     found = I_CURRENT_LIMIT;
      hrc_pkg::HRC_SRC_HERE:      found = 1'b1;
      default:                    found = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hrc_pkg::HRC_ST_IDLE: begin
        if (accept && mcfg.valid) begin
          state_d = (mcfg.src == hrc_pkg::HRC_SRC_HERE) ? hrc_pkg::HRC_ST_ZERO : hrc_pkg::HRC_ST_SEARCH;
        end
      end
      hrc_pkg::HRC_ST_SEARCH: begin
        if (found) begin
          state_d = hrc_pkg::HRC_ST_ZERO;
        end
      end
      hrc_pkg::HRC_ST_ZERO: begin
        state_d = ctrl_q[`HRC_C_POSTPOS] ? hrc_pkg::HRC_ST_GOTO : hrc_pkg::HRC_ST_STOP;
      end
      hrc_pkg::HRC_ST_GOTO, hrc_pkg::HRC_ST_STOP: begin
        if (I_IN_POS) begin
          state_d = hrc_pkg::HRC_ST_IDLE;
        end
      end
      default: state_d = hrc_pkg::HRC_ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= hrc_pkg::HRC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Direction: search toward the inactive side of the home switch first
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      run_q <= '0;
      dir_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      rev_q <= rev_now;
      if (accept) begin
        run_q <= mcfg;
        if (mcfg.src == hrc_pkg::HRC_SRC_HOME_EDGE || mcfg.src == hrc_pkg::HRC_SRC_HOME_ZP) begin
          dir_q <= mcfg.dir_pos ^ sw.home;
        end else begin
          dir_q <= mcfg.dir_pos;
        end
      end else if (state_q == hrc_pkg::HRC_ST_SEARCH && rev_now && !rev_q) begin
        dir_q <= !dir_q;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_MOVE_EN   <= 1'b0;
      O_MOVE_DIR  <= 1'b0;
      O_SET_ZERO  <= 1'b0;
      O_GOTO_ZERO <= 1'b0;
      O_BRAKE     <= 1'b0;
    end else begin
      O_MOVE_EN   <= state_d == hrc_pkg::HRC_ST_SEARCH;
      O_MOVE_DIR  <= dir_q;
      O_SET_ZERO  <= state_d == hrc_pkg::HRC_ST_ZERO;
      O_GOTO_ZERO <= state_d == hrc_pkg::HRC_ST_GOTO;
      O_BRAKE     <= state_d == hrc_pkg::HRC_ST_STOP;
    end
  end

  // ************************************************************
  // Reference status
  // ************************************************************
  logic [15:0] delta, delta_abs;
  logic        emu_ok, done;

  assign delta     = I_ANGLE - angle_q;
  assign delta_abs = delta[15] ? 16'(~delta + 16'h0001) : delta;
  assign emu_ok    = delta_abs <= win_q && delta_abs < `HRC_HALF_TURN;
  assign done      = state_q == hrc_pkg::HRC_ST_ZERO;

  // Set wins over clear: a finished run in a download cycle still counts
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      req_q <= 1'b1;
      ref_q <= 1'b0;
    end else if (done) begin
      req_q <= 1'b0;
      ref_q <= 1'b1;
    end else if (dl_w) begin
      req_q <= 1'b1;
      ref_q <= 1'b0;
    end else if (chk_w && fb == hrc_pkg::HRC_FB_ABS) begin
      req_q <= 1'b0;
      ref_q <= 1'b1;
    end else if (chk_w && fb == hrc_pkg::HRC_FB_EMU) begin
      req_q <= !emu_ok;
      ref_q <= emu_ok;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fault_q <= 1'b0;
    end else if (accept && !mcfg.valid) begin
      fault_q <= 1'b1;
    end else if (fclr_w) begin
      fault_q <= 1'b0;
    end
  end

  assign O_REFERENCED  = ref_q;
  assign O_SW_LIMIT_EN = ref_q && state_q == hrc_pkg::HRC_ST_IDLE;

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_HRDATA <= 32'h00000000;
    end else if (acc && !I_HWRITE) begin
      unique case (I_HADDR[7:0])
        `HRC_CTRL_OFS:  O_HRDATA <= {19'h00000, ctrl_q};
        `HRC_MODE_OFS:  O_HRDATA <= {24'h000000, mode_q};
        `HRC_WIN_OFS:   O_HRDATA <= {16'h0000, win_q};
        `HRC_STAT_OFS:  O_HRDATA <= {19'h00000, ref_q, 7'h00, O_SW_LIMIT_EN, req_q, fault_q, ref_q,
                                     state_q != hrc_pkg::HRC_ST_IDLE};
        `HRC_POS_OFS:   O_HRDATA <= I_POSITION;
        `HRC_ANGLE_OFS: O_HRDATA <= {16'h0000, angle_q};
        default:        O_HRDATA <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  run_on_start_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    accept && mcfg.valid |=> state_q != hrc_pkg::HRC_ST_IDLE)
    else $error("homing run not started");
  goto_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    done && ctrl_q[`HRC_C_POSTPOS] |=> O_GOTO_ZERO && !O_BRAKE)
    else $error("no move to zero after homing");
  brake_stop_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    done && !ctrl_q[`HRC_C_POSTPOS] |=> O_BRAKE && !O_GOTO_ZERO && !O_MOVE_EN)
    else $error("no brake after homing");
  abs_check_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    chk_w && fb == hrc_pkg::HRC_FB_ABS && !dl_w |=> O_REFERENCED && !req_q)
    else $error("absolute feedback not referenced");
  download_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    dl_w && !done |=> req_q && !O_REFERENCED)
    else $error("download did not demand homing");
  here_mode_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    accept && mode_q == `HRC_MODE_HERE |=> O_SET_ZERO ##1 !O_SET_ZERO)
    else $error("mode 35 did not set zero at once");
  emu_ok_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    chk_w && !dl_w && !done && fb == hrc_pkg::HRC_FB_EMU && emu_ok |=> O_REFERENCED)
    else $error("emulation within window not referenced");
  emu_bad_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    chk_w && !dl_w && !done && fb == hrc_pkg::HRC_FB_EMU && !emu_ok |=> !O_REFERENCED && !O_SW_LIMIT_EN)
    else $error("exceeded window still referenced");
  bad_mode_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    accept && !mcfg.valid |=> fault_q && state_q == hrc_pkg::HRC_ST_IDLE && !O_MOVE_EN)
    else $error("invalid mode not refused");

endmodule : hrc_top

`default_nettype wire

// >>> test/hrc_axis_model.sv
// Axis model: home and end switches, zero pulse, position and standstill
`timescale 1ns/1ns
`default_nettype none
module hrc_axis_model (
  input  wire logic        i_clk,
  input  wire logic        i_move_en,
  input  wire logic        i_move_dir,
  input  wire logic        i_set_zero,
  input  wire logic        i_goto_zero,
  input  wire logic        i_brake,
  input  wire logic        i_place,
  input  wire logic [1:0]  i_side,
  input  wire logic [2:0]  i_inv,
  input  wire logic        i_swap,
  output logic             o_home,
  output logic             o_sw_a,
  output logic             o_sw_b,
  output logic             o_zp,
  output logic             o_cur,
  output logic             o_in_pos,
  output logic      [31:0] o_pos
);
  // ************************************************************
  // Mechanics
  // ************************************************************
  localparam int LIM = 200;
  int   p_q;
  int   z_q;
  int   b_q;
  logic home_l;
  logic lim_n;
  logic lim_p;

  // Hard stop 8 steps past each end switch
  always_ff @(posedge i_clk) begin
    if (i_place) begin
      p_q <= (i_side == 2'd1) ? 60 : -60;
      z_q <= 0;
    end else begin
      if (i_move_en && i_move_dir && p_q < LIM + 8) p_q <= p_q + 1;
      if (i_move_en && !i_move_dir && p_q > -LIM - 8) p_q <= p_q - 1;
      if (!i_move_en && i_goto_zero && p_q != z_q) p_q <= (p_q > z_q) ? p_q - 1 : p_q + 1;
      if (i_set_zero) z_q <= p_q;
    end
    b_q <= i_brake ? b_q + 1 : 0;
  end

  // ************************************************************
  // Sensor pins
  // ************************************************************
  // Side 0: active on positive half, 1: negative half, 2: middle band
  assign home_l   = (i_side == 2'd0) ? (p_q >= 0) : (i_side == 2'd1) ? (p_q < 0) : (p_q > -30 && p_q < 30);
  assign lim_n    = p_q <= -LIM;
  assign lim_p    = p_q >= LIM;
  assign o_home   = home_l ^ i_inv[0];
  // Input A faces the positive end unless swapped
  assign o_sw_a   = (i_swap ? lim_n : lim_p) ^ i_inv[1];
  assign o_sw_b   = (i_swap ? lim_p : lim_n) ^ i_inv[2];
  // Four steps wide so the pulse survives the input filter
  assign o_zp     = (p_q & 31) < 4;
  assign o_cur    = p_q >= LIM + 8 || p_q <= -LIM - 8;
  assign o_in_pos = i_goto_zero ? (p_q == z_q) : i_brake ? (b_q >= 3) : !i_move_en;
  assign o_pos    = p_q - z_q;
endmodule : hrc_axis_model
`default_nettype wire

// >>> test/hrc_tb_top.sv
// Self-checking bench for the homing reference control
`include "hrc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module hrc_tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, pos, rd;
  logic        hready, hresp, home, sw_a, sw_b, zp, cur, in_pos;
  logic        move_en, move_dir, set_zero, goto_zero, brake, refd, swlim;
  logic [15:0] angle = 16'h0;
  logic        place = 1'b1;
  logic [1:0]  side = 2'h0;
  logic [2:0]  inv = 3'h0;
  logic        swap = 1'b0;
  logic        ref_e = 1'b0;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          seed = 32'h43BF;
  int          sz_cnt = 0, gz_cnt = 0, br_cnt = 0, mv_cnt = 0;

  always #4 clk = ~clk;
  always @(posedge clk) begin
    sz_cnt <= sz_cnt + (set_zero === 1'b1);
    gz_cnt <= gz_cnt + (goto_zero === 1'b1);
    br_cnt <= br_cnt + (brake === 1'b1);
    mv_cnt <= mv_cnt + (move_en === 1'b1);
  end

  hrc_top hrc_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_HOME_SW(home), .I_SWITCH_A(sw_a), .I_SWITCH_B(sw_b),
    .I_ZERO_PULSE(zp), .I_CURRENT_LIMIT(cur), .I_IN_POS(in_pos), .I_POSITION(pos), .I_ANGLE(angle),
    .O_MOVE_EN(move_en), .O_MOVE_DIR(move_dir), .O_SET_ZERO(set_zero), .O_GOTO_ZERO(goto_zero),
    .O_BRAKE(brake), .O_REFERENCED(refd), .O_SW_LIMIT_EN(swlim));

  hrc_axis_model hrc_axis_model_inst (.i_clk(clk), .i_move_en(move_en), .i_move_dir(move_dir),
    .i_set_zero(set_zero), .i_goto_zero(goto_zero), .i_brake(brake), .i_place(place), .i_side(side),
    .i_inv(inv), .i_swap(swap), .o_home(home), .o_sw_a(sw_a), .o_sw_b(sw_b), .o_zp(zp), .o_cur(cur),
    .o_in_pos(in_pos), .o_pos(pos));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdc

  function automatic logic valid(input int m);
    return m inside {[1:14], [17:30], [33:35], [128:133]};
  endfunction : valid

  // No wrap in the chosen angles, so plain distance is unambiguous
  function automatic logic emu_ok(input logic [15:0] c, input logic [15:0] s, input logic [15:0] w);
    int d;
    d = int'(c) - int'(s);
    if (d < 0) d = -d;
    return d <= int'(w) && d < 32'h8000;
  endfunction : emu_ok

  task automatic bad_run(input logic [7:0] m);
    int k;
    wr(`HRC_MODE_OFS, {24'h0, m});
    wr(`HRC_CTRL_OFS, 32'h180);
    k = sz_cnt + mv_cnt;
    wr(`HRC_CTRL_OFS, 32'h081);
    repeat (4) @(posedge clk);
    chk(sz_cnt + mv_cnt - k, 32'h0);
    rdc(`HRC_STAT_OFS, 32'h0000000C);
    wr(`HRC_STAT_OFS, 32'h4);
    rdc(`HRC_STAT_OFS, 32'h00000008);
  endtask : bad_run

  task automatic chkpt(input logic [1:0] fb, input logic [15:0] c, input logic [15:0] s, input logic [15:0] w);
    angle <= c;
    wr(`HRC_WIN_OFS, {16'h0, w});
    wr(`HRC_ANGLE_OFS, {16'h0, s});
    // The check strobe acts on the feedback type already stored
    wr(`HRC_CTRL_OFS, {19'h0, 1'b0, 1'b0, fb, 9'h0});
    wr(`HRC_CTRL_OFS, {19'h0, 1'b1, 1'b0, fb, 9'h0});
    repeat (3) @(posedge clk);
    if (fb == 2'd1) ref_e = 1'b1;
    if (fb == 2'd2) ref_e = emu_ok(c, s, w);
    chk({31'h0, refd}, {31'h0, ref_e});
    bus(1'b0, `HRC_STAT_OFS, 32'h0, rd);
    chk(rd & 32'h1012, ref_e ? 32'h1012 : 32'h0);
    if (fb == 2'd2 && !ref_e) chk(rd & 32'h8, 32'h8);
  endtask : chkpt

  task automatic run_mode(input logic [7:0] m);
    logic [31:0] c;
    logic [2:0]  iv;
    logic        post, sw;
    int          s0, g0, b0, n;
    post = 1'($random(seed));
    sw   = 1'($random(seed));
    iv   = 3'($random(seed));
    // Same sense on both end inputs when swapped
    if (sw) iv[2] = iv[1];
    inv   <= iv;
    swap  <= sw;
    side  <= (m inside {[5:6], [21:22]}) ? 2'd1 : (m inside {[7:14], [23:30]}) ? 2'd2 : 2'd0;
    place <= 1'b1;
    @(posedge clk);
    place <= 1'b0;
    c = 32'h0C0 | (32'(post) << 1) | (32'(sw) << 2) | (32'(iv) << 3);
    wr(`HRC_MODE_OFS, {24'h0, m});
    wr(`HRC_CTRL_OFS, c | 32'h100);
    s0 = sz_cnt;
    g0 = gz_cnt;
    b0 = br_cnt;
    wr(`HRC_CTRL_OFS, c | 32'h1);
    n = 0;
    while (sz_cnt == s0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    n = 0;
    while ((move_en | goto_zero | brake) !== 1'b0 && n < 800) begin
      @(posedge clk);
      n++;
    end
    chk(sz_cnt - s0, 32'h1);
    chk({31'h0, refd}, 32'h1);
    chk({31'h0, gz_cnt != g0}, {31'h0, post});
    chk({31'h0, br_cnt != b0}, {31'h0, !post});
    if (post) chk(pos, 32'h0);
    rdc(`HRC_STAT_OFS, 32'h00001012);
    s0 = sz_cnt + mv_cnt;
    wr(`HRC_CTRL_OFS, c | 32'h1);
    repeat (20) @(posedge clk);
    chk(sz_cnt + mv_cnt - s0, 32'h0);
  endtask : run_mode

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin : watchdog
    repeat (100000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin : main
    logic [7:0] bad [9] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h20, 8'h24, 8'h7F, 8'h86, 8'hFF};
    logic [7:0] m;
    repeat (6) @(posedge clk);
    rstn  <= 1'b1;
    place <= 1'b0;
    chk({29'h0, refd, swlim, move_en}, 32'h0);
    rdc(`HRC_CTRL_OFS, 32'h0);
    rdc(`HRC_MODE_OFS, 32'h0);
    rdc(`HRC_WIN_OFS, 32'h00000400);
    rdc(`HRC_STAT_OFS, 32'h00000008);
    wr(8'h18, 32'hFFFFFFFF);
    rdc(8'h18, 32'h0);
    foreach (bad[i]) bad_run(bad[i]);
    repeat (4) begin
      m = 8'($random(seed));
      if (!valid(m)) bad_run(m);
    end
    chkpt(2'd2, 16'h4000 + 16'($unsigned($random(seed)) % 32'h401), 16'h4000, 16'h0400);
    chkpt(2'd0, 16'($random(seed)), 16'h0, 16'h0400);
    chkpt(2'd2, 16'h3BFF - 16'($unsigned($random(seed)) % 32'h100), 16'h4000, 16'h0400);
    chkpt(2'd2, 16'h4000 + 16'($unsigned($random(seed)) % 32'h401), 16'h4000, 16'h0400);
    chkpt(2'd2, 16'h8000, 16'h0000, 16'hFFFF);
    chkpt(2'd1, 16'($random(seed)), 16'($random(seed)), 16'h0400);
    wr(`HRC_CTRL_OFS, 32'h300);
    bus(1'b0, `HRC_STAT_OFS, 32'h0, rd);
    chk(rd & 32'h8, 32'h8);
    for (int k = 0; k < 256; k++) begin
      if (valid(k)) run_mode(8'(k));
    end
    close_out();
  end
endmodule : hrc_tb_top
`default_nettype wire
